/* logic/teach_pkg.sv */
// Constants and types shared by the actuator teach-in controller files
package teach_pkg;

  // ****************************************************************
  // Time base
  // ****************************************************************
  localparam int CLK_MHZ     = 50;                  // 50 MHz, 20 ns period
  localparam int TICK_US     = 1000;                // One time base tick per 1 ms
  localparam int TICK_CYC    = CLK_MHZ * TICK_US;   // Clocks per tick
  localparam int STANDBY_MS  = 180000;              // Teach-in standby window, 3 min
  localparam int TEACH_MS    = 30000;               // Least dwell of actuator, 30 s
  localparam int OFF_MIN_MS  = 3000;                // Least supply-off time, 3 s
  localparam int RIDE_MS     = 5;                   // Supply gap ridden through, 5 ms
  localparam int SELFTEST_MS = 10;                  // Self-test duration after power-up
  localparam int PULSE_US    = 350;                 // Longest output test pulse, 0.35 ms
  localparam int PULSE_CYC   = CLK_MHZ * PULSE_US;  // Longest pulse in clocks, exactly 17500
  localparam int TPERIOD_MS  = 100;                 // Spacing of test pulses
  localparam int TPERIOD_CYC = TPERIOD_MS * TICK_CYC;

  // ****************************************************************
  // LED timing
  // ****************************************************************
  localparam int FLASH_MS  = 200;   // One on or off slot of a burst
  localparam int GAP_SLOTS = 4;     // Dark slots between bursts
  localparam int HALF_1HZ  = 500;   // Half period of the 1 Hz flash

  // ****************************************************************
  // Widths and codes
  // ****************************************************************
  localparam int DIV_W  = 16;
  localparam int TMR_W  = 18;
  localparam int OFF_W  = 12;
  localparam int LOW_W  = 4;
  localparam int PCNT_W = 23;
  localparam int CODE_W = 16;

  localparam logic [2:0] ERR_TEACH    = 3'h1;  // Actuator left or changed during teach
  localparam logic [2:0] ERR_READ     = 3'h3;  // Read error
  localparam logic [2:0] ERR_DISABLED = 3'h5;  // Disabled actuator seen
  localparam logic [2:0] FLASH_ONE    = 3'h1;
  localparam logic [2:0] FLASH_THREE  = 3'h3;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_SELFTEST,
    ST_STANDBY,
    ST_TEACH,
    ST_ACK,
    ST_ERR,
    ST_NORMAL,
    ST_FAULT
  } state_t;

endpackage

/* logic/led_flash.sv */
// Burst and 1 Hz flash pattern generator for the indicator LEDs
`timescale 1ns/10ps
`default_nettype none

module led_flash (
  // Clock and reset
  input  wire  logic       clk,
  input  wire  logic       rst_n,
  // Time base and pattern select
  input  wire  logic       tick,
  input  wire  logic [2:0] flashes,
  // Patterns
  output var   logic       burst,
  output var   logic       square
);

  typedef struct packed {
    logic [8:0] slot_ms;
    logic [3:0] slot;
    logic [8:0] sq_ms;
    logic       burst;
    logic       square;
  } flash_t;

  flash_t s;
  flash_t n;

  // ****************************************************************
  // Pattern sequencing
  // ****************************************************************
  // Bursts are 2*flashes slots long, then a dark gap so counts are legible
  always_comb begin
    n = s;
    if (tick) begin
      if (s.slot_ms >= 9'(teach_pkg::FLASH_MS - 1)) begin
        n.slot_ms = '0;
        if (s.slot >= 4'({flashes, 1'b0}) + 4'(teach_pkg::GAP_SLOTS - 1)) begin
          n.slot = '0;
        end else begin
          n.slot = s.slot + 1'b1;
        end
      end else begin
        n.slot_ms = s.slot_ms + 1'b1;
      end
      if (s.sq_ms >= 9'(teach_pkg::HALF_1HZ - 1)) begin
        n.sq_ms  = '0;
        n.square = ~s.square;
      end else begin
        n.sq_ms = s.sq_ms + 1'b1;
      end
    end
    n.burst = (s.slot < 4'({flashes, 1'b0})) && !s.slot[0];
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign burst  = s.burst;
  assign square = s.square;

endmodule // led_flash

`default_nettype wire

/* logic/teach_ctrl.sv */
// Actuator teach-in, code history and safety output control of an interlock switch
`timescale 1ns/10ps
`default_nettype none

module teach_ctrl #(
  parameter int                            CODE_W      = teach_pkg::CODE_W,
  parameter logic [teach_pkg::DIV_W-1:0]   TICK_CYC    = teach_pkg::DIV_W'(teach_pkg::TICK_CYC),
  parameter logic [teach_pkg::TMR_W-1:0]   STANDBY_MS  = teach_pkg::TMR_W'(teach_pkg::STANDBY_MS),
  parameter logic [teach_pkg::TMR_W-1:0]   TEACH_MS    = teach_pkg::TMR_W'(teach_pkg::TEACH_MS),
  parameter logic [teach_pkg::PCNT_W-1:0]  PULSE_CYC   = teach_pkg::PCNT_W'(teach_pkg::PULSE_CYC),
  parameter logic [teach_pkg::PCNT_W-1:0]  TPERIOD_CYC = teach_pkg::PCNT_W'(teach_pkg::TPERIOD_CYC)
) (
  // Clock and power-on reset
  input  wire  logic              CLK,
  input  wire  logic              RST_N,
  // Pins from supply and sensing head
  input  wire  logic              SUPPLY_VOLTAGE_INPUT,
  input  wire  logic              ACT_PRESENT,
  input  wire  logic              ACT_INSERTED,
  input  wire  logic [CODE_W-1:0] ACT_CODE,
  input  wire  logic              INTERNAL_FAULT,
  input  wire  logic              ACT_READ_FAULT,
  // Safety and monitoring outputs
  output var   logic              SAFETY_OUTPUT_CH1,
  output var   logic              SAFETY_OUTPUT_CH2,
  output var   logic              DOOR_POSITION_OUTPUT,
  output var   logic              DIAG_MONITOR_OUTPUT,
  // Indicator LEDs
  output var   logic              STATUS_LED,
  output var   logic              RED_FAULT_LED
);

  localparam int PIN_W = CODE_W + 5;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [PIN_W-1:0]                 sync1;
    logic [PIN_W-1:0]                 sync2;
    teach_pkg::state_t                st;
    logic [teach_pkg::DIV_W-1:0]      div;
    logic                             tick;
    logic [teach_pkg::TMR_W-1:0]      ms;
    logic [teach_pkg::LOW_W-1:0]      low_ms;
    logic [teach_pkg::OFF_W-1:0]      off_ms;
    logic [teach_pkg::PCNT_W-1:0]     pcnt;
    logic                             learned;
    logic [CODE_W-1:0]                active;
    logic                             dis_valid;
    logic [CODE_W-1:0]                disabled;
    logic                             pend_valid;
    logic [CODE_W-1:0]                pending;
    logic [CODE_W-1:0]                cand;
    logic [2:0]                       err_code;
    logic                             ch1;
    logic                             ch2;
    logic                             door;
    logic                             diag;
    logic                             green;
    logic                             red;
  } ctrl_t;

  ctrl_t s;
  ctrl_t n;

  logic              supply_s;
  logic              present_s;
  logic              inserted_s;
  logic              fault_s;
  logic              rdfault_s;
  logic [CODE_W-1:0] code_s;
  logic              lost;
  logic              permitted;
  logic [2:0]        flash_n;
  logic              burst;
  logic              square;

  // Synchronised pins, only the second stage is read
  assign {supply_s, present_s, inserted_s, fault_s, rdfault_s, code_s} = s.sync2;

  // Supply counts as lost only after the ride-through gap has passed
  assign lost = !supply_s && (s.low_ms > teach_pkg::LOW_W'(teach_pkg::RIDE_MS));

  // Newest learned code only; disabled and pending codes never qualify
  assign permitted = (s.st == teach_pkg::ST_NORMAL) && present_s && inserted_s
                     && s.learned && (code_s == s.active);

  // Flash count for the green LED bursts
  assign flash_n = (s.st == teach_pkg::ST_STANDBY) ? teach_pkg::FLASH_THREE :
                   (s.st == teach_pkg::ST_ERR)     ? s.err_code :
                                                     teach_pkg::FLASH_ONE;

  // ****************************************************************
  // Pattern generator
  // ****************************************************************
  led_flash u_flash (
    .clk     (CLK),
    .rst_n   (RST_N),
    .tick    (s.tick),
    .flashes (flash_n),
    .burst   (burst),
    .square  (square)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n       = s;
    n.sync1 = {SUPPLY_VOLTAGE_INPUT, ACT_PRESENT, ACT_INSERTED, INTERNAL_FAULT,
               ACT_READ_FAULT, ACT_CODE};
    n.sync2 = s.sync1;

    // Single time base, every timer below except the test pulse counter runs on its tick
    n.tick = 1'b0;
    if (s.div >= TICK_CYC - 1'b1) begin
      n.div  = '0;
      n.tick = 1'b1;
    end else begin
      n.div = s.div + 1'b1;
    end
    if (s.tick && (s.ms != '1)) begin
      n.ms = s.ms + 1'b1;
    end

    // Test pulse period counter runs free
    if (s.pcnt >= TPERIOD_CYC - 1'b1) begin
      n.pcnt = '0;
    end else begin
      n.pcnt = s.pcnt + 1'b1;
    end

    // Supply gap counter, saturates just above the ride-through limit
    if (supply_s) begin
      n.low_ms = '0;
    end else if (s.tick && !lost) begin
      n.low_ms = s.low_ms + 1'b1;
    end

    // Main sequence
    case (s.st)
      teach_pkg::ST_OFF: begin
        if (s.tick && (s.off_ms < teach_pkg::OFF_W'(teach_pkg::OFF_MIN_MS))) begin
          n.off_ms = s.off_ms + 1'b1;
        end
        if (supply_s) begin
          // A short dip leaves the taught code pending for the next cycle
          if ((s.off_ms >= teach_pkg::OFF_W'(teach_pkg::OFF_MIN_MS)) && s.pend_valid) begin
            n.active     = s.pending;
            n.learned    = 1'b1;
            n.pend_valid = 1'b0;
          end
          n.st = teach_pkg::ST_SELFTEST;
          n.ms = '0;
        end
      end
      teach_pkg::ST_SELFTEST: begin
        if (s.ms >= teach_pkg::TMR_W'(teach_pkg::SELFTEST_MS)) begin
          n.st = teach_pkg::ST_STANDBY;
          n.ms = '0;
        end
      end
      teach_pkg::ST_STANDBY: begin
        if (present_s && s.learned && (code_s == s.active)) begin
          n.st = teach_pkg::ST_NORMAL;
        end else if (present_s && s.dis_valid && (code_s == s.disabled)) begin
          n.st       = teach_pkg::ST_ERR;
          n.err_code = teach_pkg::ERR_DISABLED;
        end else if (present_s) begin
          // Also taken straight after self-test when the guard is already shut
          n.st   = teach_pkg::ST_TEACH;
          n.cand = code_s;
          n.ms   = '0;
        end else if (s.learned && (s.ms >= STANDBY_MS)) begin
          n.st = teach_pkg::ST_NORMAL;
        end
        // Unlearned devices have no exit but a taught actuator
      end
      teach_pkg::ST_TEACH: begin
        if (!present_s || (code_s != s.cand)) begin
          n.st       = teach_pkg::ST_ERR;
          n.err_code = teach_pkg::ERR_TEACH;
        end else if (rdfault_s) begin
          n.st       = teach_pkg::ST_ERR;
          n.err_code = teach_pkg::ERR_READ;
        end else if (s.ms > TEACH_MS) begin
          // Strictly above, a partial first tick must not shorten the dwell
          // Shift the history: one disabled slot, so the oldest code drops out
          n.st         = teach_pkg::ST_ACK;
          n.dis_valid  = s.pend_valid || s.learned;
          n.disabled   = s.pend_valid ? s.pending : s.active;
          n.pending    = s.cand;
          n.pend_valid = 1'b1;
          // No teach counter exists, teach-in may repeat without end
        end
      end
      teach_pkg::ST_NORMAL: begin
        if (present_s && rdfault_s) begin
          n.st       = teach_pkg::ST_ERR;
          n.err_code = teach_pkg::ERR_READ;
        end else if (present_s && s.dis_valid && (code_s == s.disabled)) begin
          n.st       = teach_pkg::ST_ERR;
          n.err_code = teach_pkg::ERR_DISABLED;
        end
      end
      default: begin
        // Acknowledge, error and fault hold until the supply is cycled
      end
    endcase

    // Faults win over any teach step, supply loss wins over all
    if ((s.st != teach_pkg::ST_OFF) && fault_s) begin
      n.st = teach_pkg::ST_FAULT;
    end
    if ((s.st != teach_pkg::ST_OFF) && lost) begin
      n.st     = teach_pkg::ST_OFF;
      n.off_ms = '0;
    end

    // Outputs, staggered off pulses so channels never test together
    n.ch1  = permitted && (s.pcnt >= PULSE_CYC);
    n.ch2  = permitted && ((s.pcnt < (TPERIOD_CYC >> 1))
                           || (s.pcnt >= (TPERIOD_CYC >> 1) + PULSE_CYC));
    n.door = inserted_s && (s.st != teach_pkg::ST_OFF)
             && (s.st != teach_pkg::ST_FAULT);

    // Indicator patterns
    case (s.st)
      teach_pkg::ST_STANDBY: begin
        n.green = burst;
        n.red   = 1'b0;
      end
      teach_pkg::ST_TEACH: begin
        n.green = square;
        n.red   = 1'b0;
      end
      teach_pkg::ST_ACK: begin
        n.green = square;
        n.red   = !square;
      end
      teach_pkg::ST_ERR: begin
        n.green = burst;
        n.red   = 1'b1;
      end
      teach_pkg::ST_NORMAL: begin
        n.green = inserted_s ? 1'b1 : burst;
        n.red   = 1'b0;
      end
      teach_pkg::ST_FAULT: begin
        n.green = 1'b0;
        n.red   = 1'b1;
      end
      default: begin
        n.green = 1'b0;
        n.red   = 1'b0;
      end
    endcase
    n.diag = n.red;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset is the factory state: nothing learned, supply taken as off
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign SAFETY_OUTPUT_CH1    = s.ch1;
  assign SAFETY_OUTPUT_CH2    = s.ch2;
  assign DOOR_POSITION_OUTPUT = s.door;
  assign DIAG_MONITOR_OUTPUT  = s.diag;
  assign STATUS_LED           = s.green;
  assign RED_FAULT_LED        = s.red;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence teach_done_s;
    (s.st == teach_pkg::ST_TEACH) ##1 (s.st == teach_pkg::ST_ACK);
  endsequence

  teach_outputs_off_a: assert property ((s.st == teach_pkg::ST_TEACH) |=>
    (!SAFETY_OUTPUT_CH1 && !SAFETY_OUTPUT_CH2))
    else $error("safety channel on during teach-in");

  fault_blocks_teach_a: assert property ((fault_s && !lost
    && (s.st != teach_pkg::ST_OFF)) |=> (s.st == teach_pkg::ST_FAULT))
    else $error("teach-in possible with internal fault");

  unlearned_standby_a: assert property ((s.st == teach_pkg::ST_STANDBY && !s.learned
    && !present_s && !fault_s && !lost) |=> (s.st == teach_pkg::ST_STANDBY))
    else $error("unlearned device left standby");

  standby_timeout_a: assert property ((s.st == teach_pkg::ST_STANDBY && s.learned
    && s.ms >= STANDBY_MS) |=> (s.st != teach_pkg::ST_STANDBY))
    else $error("standby window not ended");

  history_shift_a: assert property (teach_done_s |->
    (s.pending == $past(s.cand) && s.disabled == ($past(s.pend_valid) ? $past(s.pending)
                                                   : $past(s.active))))
    else $error("code history not shifted on teach");

  newest_code_a: assert property (SAFETY_OUTPUT_CH1 |->
    ($past(code_s) == $past(s.active) && $past(s.st) == teach_pkg::ST_NORMAL))
    else $error("channel on for a code other than the newest");

  newest_ends_standby_a: assert property ((s.st == teach_pkg::ST_STANDBY && present_s
    && s.learned && code_s == s.active && !fault_s && !lost) |=> (s.st == teach_pkg::ST_NORMAL))
    else $error("newest actuator did not end standby");

  teach_dwell_a: assert property (teach_done_s |-> ($past(s.ms) >= TEACH_MS))
    else $error("teach-in acknowledged before dwell");

  door_follows_a: assert property (DOOR_POSITION_OUTPUT |-> $past(inserted_s))
    else $error("door output without inserted actuator");

  ack_alternate_a: assert property ((s.st == teach_pkg::ST_ACK) |=>
    (STATUS_LED != RED_FAULT_LED))
    else $error("acknowledge LEDs not alternating");

  error_red_a: assert property ((s.st == teach_pkg::ST_ERR) |=>
    (RED_FAULT_LED && DIAG_MONITOR_OUTPUT))
    else $error("red LED not steady on teach-in error");

endmodule // teach_ctrl

`default_nettype wire

/* testbench/safe_plc.sv */
// Safe control system model that reads the two pulsed safety channels
`timescale 1ns/10ps
`default_nettype none

module safe_plc #(
  parameter int FILT = 3
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Safety channels and operator start
  input  wire logic ch1,
  input  wire logic ch2,
  input  wire logic start,
  // Filtered view and machine state
  output var  logic safe,
  output var  logic run
);
  int lo1;
  int lo2;

  // Low time of each channel; short lows are only test pulses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lo1 <= 100;
      lo2 <= 100;
    end else begin
      lo1 <= ch1 ? 0 : lo1 + 1;
      lo2 <= ch2 ? 0 : lo2 + 1;
    end
  end

  // Neither channel alone may enable the machine
  assign safe = rst_n && lo1 <= FILT && lo2 <= FILT;

  // Runs only after an explicit start, never on closure or power-up
  always_ff @(posedge clk) begin
    if (!rst_n || !safe) begin
      run <= 1'b0;
    end else if (start) begin
      run <= 1'b1;
    end
  end
endmodule  // safe_plc

`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the actuator teach-in controller
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ****************************************************************
  // Settings and signals
  // ****************************************************************
  localparam int          TCK = 10;  // Clocks per shortened tick
  localparam int          TCH = 20;  // Shortened teach dwell
  localparam logic [15:0] CA  = 16'h0a11;
  localparam logic [15:0] CB  = 16'h0b22;
  localparam logic [15:0] CC  = 16'h0c33;

  logic        CLK;
  logic        RST_N;
  logic        sup;
  logic        pres;
  logic        ins;
  logic        ifault;
  logic        rfault;
  logic        start;
  logic [15:0] code;
  logic        ch1;
  logic        ch2;
  logic        door;
  logic        diag;
  logic        grn;
  logic        red;
  logic        safe;
  logic        run;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;

  // Clock
  initial CLK = 1'b0;
  always #10 CLK = ~CLK;

  // Shortened time base so a power cycle fits the run
  teach_ctrl #(.TICK_CYC(16'h000a), .STANDBY_MS(18'h00032), .TEACH_MS(18'h00014),
    .PULSE_CYC(23'h000003), .TPERIOD_CYC(23'h000028)) teach_ctrl_i (
    .CLK(CLK), .RST_N(RST_N), .SUPPLY_VOLTAGE_INPUT(sup), .ACT_PRESENT(pres),
    .ACT_INSERTED(ins), .ACT_CODE(code), .INTERNAL_FAULT(ifault),
    .ACT_READ_FAULT(rfault), .SAFETY_OUTPUT_CH1(ch1), .SAFETY_OUTPUT_CH2(ch2),
    .DOOR_POSITION_OUTPUT(door), .DIAG_MONITOR_OUTPUT(diag), .STATUS_LED(grn),
    .RED_FAULT_LED(red));

  safe_plc safe_plc_i (.clk(CLK), .rst_n(RST_N), .ch1(ch1), .ch2(ch2),
    .start(start), .safe(safe), .run(run));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Wait whole ticks, then step off the edge
  task automatic tk(input int n);
    repeat (n * TCK) @(posedge CLK);
    #1;
  endtask

  task automatic act(input logic p, input logic [15:0] c);
    pres = p;
    ins = p;
    code = c;
  endtask

  // Supply off for a number of ticks, back on until standby
  task automatic cycle(input int off);
    sup = 1'b0;
    tk(off);
    sup = 1'b1;
    tk(14);
  endtask

  // Full dwell; channels must never come on meanwhile
  task automatic teach(input logic [15:0] c);
    int hi;
    hi = 0;
    act(1'b1, c);
    repeat ((TCH + 3) * TCK) begin
      @(posedge CLK);
      #1;
      hi += int'(ch1 | ch2);
    end
    chk(8'(hi), 8'h00);
    chk({7'h0, door}, 8'h01);
    chk({7'h0, grn ^ red}, 8'h01);
    act(1'b0, c);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_fault();
    ifault = 1'b1;
    sup = 1'b1;
    tk(14);
    act(1'b1, CA);
    tk(5);
    chk({3'h0, ch1, ch2, red, grn, diag}, 8'h05);
    act(1'b0, CA);
    ifault = 1'b0;
    cycle(10);
  endtask

  // Unlearned standby outlasts the window; early removal aborts
  task automatic t_short();
    tk(100);
    act(1'b1, CA);
    tk(10);
    chk({5'h0, ch1, ch2, red}, 8'h00);
    act(1'b0, CA);
    tk(3);
    chk({5'h0, ch1, ch2, red}, 8'h01);
    cycle(10);
  endtask

  task automatic t_norm_a();
    cycle(3010);
    act(1'b1, CA);
    tk(2);
    chk({6'h0, safe, run}, 8'h02);
    chk({7'h0, grn}, 8'h01);
    start = 1'b1;
    tk(1);
    start = 1'b0;
    chk({7'h0, run}, 8'h01);
    sup = 1'b0;
    tk(3);
    sup = 1'b1;
    chk({6'h0, door, red}, 8'h02);
    tk(2);
    chk({6'h0, door, red}, 8'h02);
    act(1'b0, CA);
    tk(1);
    chk({5'h0, safe, run, door}, 8'h00);
    act(1'b1, CA);
    tk(2);
    chk({6'h0, safe, run}, 8'h02);
    rfault = 1'b1;
    tk(2);
    chk({5'h0, ch1, ch2, red}, 8'h01);
    rfault = 1'b0;
    act(1'b0, CA);
  endtask

  task automatic t_b();
    cycle(10);
    teach(CB);
    cycle(3010);
    act(1'b1, CB);
    tk(2);
    chk({7'h0, safe}, 8'h01);
    act(1'b0, CB);
    cycle(10);
    tk(60);
    act(1'b1, CC);
    tk(5);
    chk({6'h0, safe, door}, 8'h01);
    act(1'b0, CC);
    tk(3);
    chk({7'h0, red}, 8'h00);
    act(1'b1, CA);
    tk(3);
    chk({5'h0, ch1, ch2, red}, 8'h01);
    act(1'b0, CA);
  endtask

  // Third code frees the first; actuator present at power-up starts teach
  task automatic t_c();
    cycle(10);
    teach(CC);
    act(1'b1, CA);
    cycle(10);
    chk({6'h0, door, red}, 8'h02);
    tk(20);
    chk({7'h0, grn ^ red}, 8'h01);
    act(1'b0, CA);
  endtask

  // ****************************************************************
  // Main sequence and hang guard
  // ****************************************************************
  initial begin
    RST_N = 1'b0;
    sup = 1'b0;
    ifault = 1'b0;
    rfault = 1'b0;
    start = 1'b0;
    act(1'b0, CA);
    repeat (10) @(posedge CLK);
    #1;
    RST_N = 1'b1;
    t_fault();
    t_short();
    teach(CA);
    t_norm_a();
    t_b();
    t_c();
    close_out();
  end

  // Whole run is about 65000 clocks
  always @(posedge CLK) begin
    cyc++;
    if (cyc > 80000) begin
      n_mismatch++;
      close_out();
    end
  end
endmodule  // tb

`default_nettype wire
